// ==== rtl/trace_pkg.sv ====
// constants, types and helpers for the trace capture and readout block
// assumes a 32-bit axi4-lite register bus and a 16-bit core address bus
package trace_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFS_COMP_A = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_TRIG = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_FIFO_HI = 8'h10;
  localparam logic [7:0] OFS_FIFO_LO = 8'h14;
  localparam logic [7:0] OFS_COUNT = 8'h18;
  // field positions
  localparam int STAT_ARMED_BIT = 6;
  // reset values of the default begin run
  localparam logic [7:0] CTRL_RST = 8'hC0;
  localparam logic [7:0] TRIG_RST = 8'h40;
  localparam logic [23:0] COMP_A_RST = 24'h00FFFE;
  // fifo shape and the branch source correction
  localparam int FIFO_DEPTH = 8;
  localparam int COUNT_W = 4;
  localparam logic [15:0] BRANCH_ADJ = 16'h0002;
  localparam logic [7:0] EVENT_HI = 8'h00;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [3:0] {
    MODE_A_ONLY = 4'h0,
    MODE_A_OR_B = 4'h1,
    MODE_A_THEN_B = 4'h2,
    MODE_EVENT_B = 4'h3,
    MODE_A_THEN_EVENT_B = 4'h4,
    MODE_A_AND_B = 4'h5,
    MODE_A_AND_NOT_B = 4'h6,
    MODE_INSIDE = 4'h7,
    MODE_OUTSIDE = 4'h8
  } trig_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_STORE = 3'b100
  } cap_state_t;

  typedef struct packed {
    logic enable;
    logic arm;
    logic brk_en;
    logic tag;
    logic [3:0] rsvd;
  } ctrl_t;

  typedef struct packed {
    logic op_sel;
    logic begin_sel;
    logic [1:0] rsvd;
    trig_mode_t mode;
  } trig_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] op_addr;
    logic [1:0] cof;
    logic [7:0] data;
    logic trigger;
    logic irq_pending;
  } core_in_t;

  // event-only modes store data bus values and always run as begin runs
  function automatic logic is_event_only(input trig_mode_t m);
    return (m == MODE_EVENT_B) || (m == MODE_A_THEN_EVENT_B);
  endfunction

  function automatic logic is_begin_run(input trig_t t);
    return t.begin_sel || is_event_only(t.mode);
  endfunction
endpackage

// ==== rtl/trace_capture.sv ====
// trace fifo capture and readout of the on-chip debug module, axi4-lite slave
// assumes trigger, change-of-flow and irq inputs are synchronous to clk_sys
// What this block does
// RULE_01: event-only modes never run as end-trigger; they always capture as begin runs. (other resets still treat them as end runs while begin_sel is clear)
// RULE_02: an armed end run stores qualifying addresses continuously until the trigger.
// RULE_03: an indirect jump, return or vector flow change pushes the current address.
// RULE_04: a taken branch pushes the previous cycle's address minus two.
// RULE_05: the end trigger clears arm and armed flag and stops storing.
// RULE_06: an end-run trigger on a flow change still stores that event.
// RULE_07: fifo reads are served while enabled with arm clear.
// RULE_08: words come out oldest first; the count shows words captured.
// RULE_09: high byte may be read first; each low read shifts, count stays.
// RULE_10: in event-only modes the host needs only the low byte register.
// RULE_11: a read while armed returns the oldest word and does not shift.
// RULE_12: unarmed low byte reads store the current opcode address (profile mode).
// RULE_13: with opcode triggering, a coincident pending interrupt blocks the trigger.
// RULE_14: fetch-triggered end runs disarm despite irq without storing its flow change.
// RULE_15: fetch-triggered begin runs trigger despite irq, store it and stay armed.
// RULE_16: the block never requests a reset of the microcontroller.
// RULE_17: reset during an end run clears arm, armed flag, breakpoint enable only.
// RULE_18: any other reset loads comparator a with 0xFFFE and extension 0x00.
// RULE_19: such a reset loads the control register with 0xC0.
// RULE_20: such a reset loads the trigger register with 0x40.
// RULE_21: the trace fifo holds exactly eight words.
// RULE_22: in event-only modes the high byte of each word reads 0x00.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module trace_capture #(
  parameter int DEPTH = trace_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys, // 10 MHz bus clock
  input wire logic rst_n, // power-on reset, async, active low
  input wire logic sys_reset, // other mcu reset, synchronous level
  input wire trace_pkg::core_in_t core_in, // core address, flow and trigger inputs
  input wire logic [trace_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [trace_pkg::DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [trace_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [trace_pkg::DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output trace_pkg::ctrl_t ctrl_out, // control bits to comparator logic
  output trace_pkg::trig_t trig_out, // trigger setup to comparator logic
  output logic [23:0] comp_a_out, // comparator a match value
  output logic halt_req, // one-cycle cpu breakpoint request
  output logic reset_req // mcu reset request, held low
);
  import trace_pkg::*;

  logic rst_meta_r, rst_sync_n;
  logic aw_hold_r, w_hold_r, aw_hold_nxt, w_hold_nxt, wr_fire;
  logic [ADDR_W-1:0] awaddr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [3:0] wstrb_r;
  ctrl_t ctrl_r;
  trig_t trig_r;
  logic [23:0] comp_a_r;
  logic armed_r, halt_r, reset_req_r;
  cap_state_t state_r;
  logic [15:0] prev_addr_r;
  logic [15:0] mem_r [DEPTH];
  logic [COUNT_W-1:0] count_r;
  logic wr_ctrl, active, begin_run, event_mode, trig_eff, hw_disarm;
  logic push, fl_read, readable, run_start;
  logic [15:0] push_word;

  // reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // write address and data are held independently, then committed together
  assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign aw_hold_nxt = !wr_fire && (aw_hold_r || (s_axi_awvalid && s_axi_awready));
  assign w_hold_nxt = !wr_fire && (w_hold_r || (s_axi_wvalid && s_axi_wready));

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      s_axi_awready <= !aw_hold_nxt;
      s_axi_wready <= !w_hold_nxt;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  // write response one cycle after commit
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_r == OFS_COMP_A || awaddr_r == OFS_CTRL ||
                      awaddr_r == OFS_TRIG) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign wr_ctrl = wr_fire && awaddr_r == OFS_CTRL && wstrb_r[0];

  // configuration registers; a software write of arm beats the hardware clear
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      // RULE_18 RULE_19 RULE_20 default begin run
      ctrl_r <= ctrl_t'(CTRL_RST);
      trig_r <= trig_t'(TRIG_RST);
      comp_a_r <= COMP_A_RST;
    end else if (sys_reset) begin
      // RULE_17 end run survives reset
      if (ctrl_r.enable && !trig_r.begin_sel) begin
        ctrl_r.arm <= 1'b0;
        ctrl_r.brk_en <= 1'b0;
      end else begin
        // RULE_18 RULE_19 RULE_20 default run again
        ctrl_r <= ctrl_t'(CTRL_RST);
        trig_r <= trig_t'(TRIG_RST);
        comp_a_r <= COMP_A_RST;
      end
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= ctrl_t'({wdata_r[7:4], 4'h0});
      end else if (hw_disarm) begin
        // RULE_05 hardware disarm
        ctrl_r.arm <= 1'b0;
      end
      if (wr_fire && awaddr_r == OFS_TRIG && wstrb_r[0]) begin
        trig_r <= trig_t'({wdata_r[7:6], 2'b00, wdata_r[3:0]});
      end
      if (wr_fire && awaddr_r == OFS_COMP_A) begin
        for (int b = 0; b < 3; b++) begin
          if (wstrb_r[b]) begin
            comp_a_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
          end
        end
      end
    end
  end

  // run decoding
  // RULE_01 event-only forces begin
  assign event_mode = is_event_only(trig_r.mode);
  assign begin_run = is_begin_run(trig_r);
  assign active = ctrl_r.enable && ctrl_r.arm;
  // RULE_13 irq beats opcode trigger
  assign trig_eff = core_in.trigger && !(trig_r.op_sel && core_in.irq_pending);
  // a reset pulse never opens a run, so a kept end-run count survives it
  assign run_start = state_r == ST_IDLE && active && !sys_reset;

  // choose the word to store and whether to store it
  always_comb begin
    push = 1'b0;
    // RULE_03 RULE_04 destination or branch source
    push_word = core_in.cof[1] ? core_in.addr : prev_addr_r - BRANCH_ADJ;
    if (event_mode) begin
      // RULE_22 event words carry a zero high byte
      push_word = {EVENT_HI, core_in.data};
      push = state_r != ST_IDLE && trig_eff && active;
    end else if (active && core_in.cof != 2'b00) begin
      if (begin_run) begin
        // RULE_15 trigger cycle flow change is captured
        push = state_r == ST_STORE || (state_r == ST_WAIT && trig_eff);
      end else begin
        // RULE_02 RULE_06 store up to and including the trigger
        // RULE_14 interrupt flow change on trigger not recorded
        push = state_r == ST_STORE &&
               !(trig_eff && core_in.irq_pending && !trig_r.op_sel);
      end
    end
  end

  // RULE_05 end trigger or full begin fifo disarms
  assign hw_disarm = active && state_r == ST_STORE &&
                     (begin_run ? (push && count_r == COUNT_W'(DEPTH - 1)) : trig_eff);

  // capture state machine
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (run_start) begin
            state_r <= begin_run ? ST_WAIT : ST_STORE;
          end
        end
        ST_WAIT: begin
          if (!active || sys_reset) begin
            state_r <= ST_IDLE;
          end else if (trig_eff) begin
            state_r <= ST_STORE;
          end
        end
        ST_STORE: begin
          if (!active || sys_reset || hw_disarm) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // armed flag follows arm and enable, dropped at once on hardware disarm
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      armed_r <= 1'b0;
      halt_r <= 1'b0;
      reset_req_r <= 1'b0;
      prev_addr_r <= '0;
    end else begin
      armed_r <= active && !hw_disarm && !sys_reset;
      halt_r <= hw_disarm && ctrl_r.brk_en;
      // RULE_16 never request a reset
      reset_req_r <= 1'b0;
      prev_addr_r <= core_in.addr;
    end
  end

  // RULE_07 reads served when enabled and not armed
  assign readable = ctrl_r.enable && !ctrl_r.arm && !armed_r;
  assign fl_read = s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_FIFO_LO;

  // trace fifo, slot 0 is the oldest word
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (run_start) begin
      count_r <= '0;
    end else if (push) begin
      // a push outranks a read in the same cycle; that read neither shifts nor samples
      // RULE_21 eight slots, oldest falls out
      if (count_r < COUNT_W'(DEPTH)) begin
        mem_r[count_r[COUNT_W-2:0]] <= push_word;
        count_r <= count_r + 1'b1;
      end else begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          mem_r[i] <= mem_r[i+1];
        end
        mem_r[DEPTH-1] <= push_word;
      end
    end else if (fl_read && readable) begin
      // RULE_08 RULE_09 shift on low read, count kept
      for (int i = 0; i < DEPTH - 1; i++) begin
        mem_r[i] <= mem_r[i+1];
      end
      // RULE_12 profile sample enters the tail
      mem_r[DEPTH-1] <= core_in.op_addr;
    end
  end

  // read channel: data one cycle after the address is taken
  // RULE_11 armed reads see the oldest word without a shift
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      unique case (s_axi_araddr)
        OFS_COMP_A: s_axi_rdata[23:0] <= comp_a_r;
        OFS_CTRL: s_axi_rdata[7:0] <= ctrl_r;
        OFS_TRIG: s_axi_rdata[7:0] <= trig_r;
        OFS_STAT: s_axi_rdata[STAT_ARMED_BIT] <= armed_r;
        OFS_FIFO_HI: s_axi_rdata[7:0] <= ctrl_r.enable ? mem_r[0][15:8] : 8'h00;
        OFS_FIFO_LO: s_axi_rdata[7:0] <= ctrl_r.enable ? mem_r[0][7:0] : 8'h00;
        OFS_COUNT: s_axi_rdata[COUNT_W-1:0] <= count_r;
        default: s_axi_rresp <= RESP_DECERR;
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // outputs straight from flip-flops
  assign ctrl_out = ctrl_r;
  assign trig_out = trig_r;
  assign comp_a_out = comp_a_r;
  assign halt_req = halt_r;
  assign reset_req = reset_req_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_n);

  // bus, reset and capture checks
  a_no_reset_req: assert property (!reset_req) // RULE_16
    else $error("reset request raised");
  a_branch_source: assert property (push && !event_mode && core_in.cof == 2'b01 // RULE_04
      |-> push_word == $past(core_in.addr) - BRANCH_ADJ)
    else $error("branch word is not previous address minus two");
  a_end_disarm: assert property (active && !begin_run && state_r == ST_STORE && trig_eff // RULE_05
      && !wr_ctrl && !sys_reset |=> !ctrl_r.arm && !armed_r && state_r == ST_IDLE)
    else $error("end trigger did not disarm");
  a_armed_read: assert property (fl_read && armed_r && !push && !run_start // RULE_11
      |=> mem_r[0] == $past(mem_r[0]))
    else $error("armed read shifted the fifo");
  a_read_shift: assert property (fl_read && readable && !push && !run_start // RULE_09
      |=> mem_r[0] == $past(mem_r[1]) && count_r == $past(count_r))
    else $error("low read did not shift or changed count");
  a_irq_opcode: assert property (active && trig_r.op_sel && core_in.irq_pending // RULE_13
      && !sys_reset && !wr_ctrl && (state_r == ST_WAIT || (state_r == ST_STORE && !begin_run))
      |=> state_r == $past(state_r))
    else $error("opcode trigger taken under pending irq");
  a_event_high: assert property (push && event_mode && !count_r[COUNT_W-1] // RULE_22
      |=> mem_r[$past(count_r[COUNT_W-2:0])][15:8] == EVENT_HI)
    else $error("event word high byte not zero");
  a_count_max: assert property (count_r <= COUNT_W'(DEPTH)) // RULE_21
    else $error("fifo count above depth");
  a_sysrst_end: assert property (sys_reset && ctrl_r.enable && !trig_r.begin_sel // RULE_17
      |=> ctrl_r.enable && !ctrl_r.arm && !ctrl_r.brk_en ##1 !armed_r)
    else $error("end run reset did not keep results");
  a_sysrst_dflt: assert property (sys_reset && !(ctrl_r.enable && !trig_r.begin_sel) // RULE_19
      |=> ctrl_r == ctrl_t'(CTRL_RST) && trig_r == trig_t'(TRIG_RST) && comp_a_r == COMP_A_RST)
    else $error("default reset values not loaded");

  // stored words and the run end as seen in the fifo and control bits
  a_dest_store: assert property (push && !event_mode && core_in.cof[1] // RULE_03
      && !count_r[COUNT_W-1] |=> mem_r[$past(count_r[COUNT_W-2:0])] == $past(core_in.addr))
    else $error("flow destination not stored");
  a_profile_tail: assert property (fl_read && readable && !push && !run_start // RULE_12
      |=> mem_r[DEPTH-1] == $past(core_in.op_addr))
    else $error("profile sample not stored");
  a_begin_full: assert property (active && begin_run && state_r != ST_IDLE && push // RULE_15
      && count_r < COUNT_W'(DEPTH - 1) && !sys_reset && !wr_ctrl |=> ctrl_r.arm)
    else $error("begin run disarmed before the fifo filled");

  // breakpoint request follows the disarm that causes it
  a_halt_brk: assert property (hw_disarm && ctrl_r.brk_en |=> halt_req) // RULE_14
    else $error("breakpoint not requested at disarm");
endmodule

// ==== test/host_dbg.sv ====
// host debugger model: axi4-lite master reaching the trace block registers
// assumes one clock; the slave answers each channel in its own time
`timescale 1ns/100ps
module host_dbg (
  input wire logic clk_sys, // bus clock
  output logic [trace_pkg::ADDR_W-1:0] awaddr, // write address
  output logic awvalid, // write address valid
  input wire logic awready, // write address ready
  output logic [trace_pkg::DATA_W-1:0] wdata, // write data
  output logic [3:0] wstrb, // byte enables
  output logic wvalid, // write data valid
  input wire logic wready, // write data ready
  input wire logic [1:0] bresp, // write response
  input wire logic bvalid, // write response valid
  output logic bready, // write response ready
  output logic [trace_pkg::ADDR_W-1:0] araddr, // read address
  output logic arvalid, // read address valid
  input wire logic arready, // read address ready
  input wire logic [trace_pkg::DATA_W-1:0] rdata, // read data
  input wire logic [1:0] rresp, // read response
  input wire logic rvalid, // read data valid
  output logic rready // read data ready
);
  import trace_pkg::*;
  // idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // write: both channels offered, each released on its handshake, payload inverted
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'b111;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~v;
      end
    end
    do @(posedge clk_sys); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  // read: address released on its handshake, data taken when rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk_sys);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge clk_sys); while (!rvalid);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_word(output logic [15:0] w);
    logic [31:0] hi;
    logic [31:0] lo;
    logic [1:0] resp;
    rd(OFS_FIFO_HI, hi, resp);
    rd(OFS_FIFO_LO, lo, resp);
    w = {hi[7:0], lo[7:0]};
  endtask
  task automatic rd_lo(output logic [7:0] b);
    logic [31:0] lo;
    logic [1:0] resp;
    rd(OFS_FIFO_LO, lo, resp);
    b = lo[7:0];
  endtask
endmodule

// ==== test/trace_capture_tb_top.sv ====
// testbench for the trace capture block: register calls plus core-side events
// assumes host_dbg as bus master and a 10 MHz clock
`timescale 1ns/100ps
module trace_capture_tb_top;
  import trace_pkg::*;
  logic clk_sys, rst_n, sys_reset, halt_req, reset_req, rr_bad;
  core_in_t core_in;
  logic [7:0] awaddr, araddr, dv;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  ctrl_t ctrl_out;
  trig_t trig_out;
  logic [23:0] comp_a_out;
  logic [15:0] w;
  logic [15:0] exp_q[$];
  int n_mismatch, cmp_count, halt_cnt;

  trace_capture #(.DEPTH(8)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .sys_reset(sys_reset),
    .core_in(core_in), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ctrl_out(ctrl_out), .trig_out(trig_out), .comp_a_out(comp_a_out),
    .halt_req(halt_req), .reset_req(reset_req));
  host_dbg u_host (.clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // counts halt pulses and latches any reset request
  always @(posedge clk_sys) begin
    if (halt_req === 1'b1) halt_cnt <= halt_cnt + 1;
    if (reset_req !== 1'b0) rr_bad <= 1'b1;
  end
  // hang guard, about ten thousand cycles
  initial begin
    #1000000;
    n_mismatch++;
    wrap_up();
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    u_host.rd(a, d, r);
    chk(d, e);
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] v);
    u_host.wr(a, v, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic armed(input logic e);
    u_host.rd(OFS_STAT, d, r);
    chk({31'h0, d[STAT_ARMED_BIT]}, {31'h0, e});
  endtask
  // one core cycle: address, flow change, trigger, irq and data
  task automatic cyc(input logic [15:0] a, input logic [1:0] f, input logic t, input logic q,
                     input logic [7:0] dd);
    @(posedge clk_sys);
    core_in <= '{addr:a, op_addr:core_in.op_addr, cof:f, data:dd, trigger:t, irq_pending:q};
  endtask
  task automatic idle(input int n);
    repeat (n) cyc(16'h0000, 2'b00, 1'b0, 1'b0, 8'h00);
  endtask
  task automatic pulse_sys_reset();
    @(posedge clk_sys);
    sys_reset <= 1'b1;
    @(posedge clk_sys);
    sys_reset <= 1'b0;
  endtask
  // reads out the fifo and compares against the expectation queue
  task automatic drain(input bit lo_only);
    logic [15:0] e;
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (lo_only) begin
        u_host.rd_lo(dv);
        w = {8'h00, dv};
      end else begin
        u_host.rd_word(w);
      end
      chk({16'h0000, w}, {16'h0000, e});
    end
  endtask
  task wrap_up();
    $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    {rst_n, sys_reset, rr_bad} = 3'b000;
    core_in = '0;
    {n_mismatch, cmp_count, halt_cnt} = '0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    idle(6);
    // power-on defaults and an unmapped read
    rdc(OFS_CTRL, 32'h0000_00C0);
    rdc(OFS_TRIG, 32'h0000_0040);
    rdc(OFS_COMP_A, 32'h0000_FFFE);
    armed(1'b1);
    chk({24'h0, ctrl_out}, 32'h0000_00C0);
    chk({24'h0, trig_out}, 32'h0000_0040);
    chk({8'h0, comp_a_out}, 32'h0000_FFFE);
    u_host.rd(8'h1C, d, r);
    chk({30'h0, r}, 32'h0000_0003);
    // default begin run: trigger with pending irq, eight words then disarm
    cyc(16'hA000, 2'b10, 1'b1, 1'b1, 8'h00);
    exp_q.push_back(16'hA000);
    for (int i = 1; i < 8; i++) begin
      cyc(16'hA000 + 16'(i) * 16'h0111, 2'b10, 1'b0, 1'b0, 8'h00);
      exp_q.push_back(16'hA000 + 16'(i) * 16'h0111);
      if (i == 6) begin
        idle(1);
        rdc(OFS_CTRL, 32'h0000_00C0);
      end
    end
    cyc(16'hB000, 2'b10, 1'b0, 1'b0, 8'h00);
    idle(4);
    rdc(OFS_CTRL, 32'h0000_0080);
    rdc(OFS_COUNT, 32'h0000_0008);
    drain(1'b0);
    rdc(OFS_COUNT, 32'h0000_0008);
    // end run: branch source, read while armed, trigger on a flow change
    wrc(OFS_TRIG, 32'h0000_0000);
    wrc(OFS_CTRL, 32'h0000_00C0);
    idle(4);
    cyc(16'h1234, 2'b10, 1'b0, 1'b0, 8'h00);
    cyc(16'h1010, 2'b00, 1'b0, 1'b0, 8'h00);
    cyc(16'h1020, 2'b01, 1'b0, 1'b0, 8'h00);
    idle(2);
    rdc(OFS_FIFO_LO, 32'h0000_0034);
    exp_q = '{16'h1234, 16'h100E, 16'h2000, 16'h2010, 16'h2020, 16'h2030, 16'h3000};
    for (int i = 0; i < 4; i++) cyc(16'h2000 + 16'(i) * 16'h0010, 2'b10, 1'b0, 1'b0, 8'h00);
    cyc(16'h3000, 2'b10, 1'b1, 1'b0, 8'h00);
    cyc(16'h4000, 2'b10, 1'b0, 1'b0, 8'h00);
    idle(4);
    rdc(OFS_CTRL, 32'h0000_0080);
    armed(1'b0);
    rdc(OFS_COUNT, 32'h0000_0007);
    drain(1'b0);
    // end run with breakpoint: fetch trigger beside a pending irq
    wrc(OFS_CTRL, 32'h0000_00E0);
    idle(4);
    cyc(16'h5000, 2'b10, 1'b0, 1'b0, 8'h00);
    cyc(16'h5100, 2'b10, 1'b1, 1'b1, 8'h00);
    idle(4);
    rdc(OFS_CTRL, 32'h0000_00A0);
    chk(32'(halt_cnt), 32'h0000_0001);
    rdc(OFS_COUNT, 32'h0000_0001);
    exp_q.push_back(16'h5000);
    drain(1'b0);
    // opcode triggering: a coincident irq blocks the trigger
    wrc(OFS_TRIG, 32'h0000_0080);
    wrc(OFS_CTRL, 32'h0000_00C0);
    idle(4);
    cyc(16'h6000, 2'b00, 1'b1, 1'b1, 8'h00);
    idle(3);
    rdc(OFS_CTRL, 32'h0000_00C0);
    cyc(16'h6100, 2'b00, 1'b1, 1'b0, 8'h00);
    idle(3);
    rdc(OFS_CTRL, 32'h0000_0080);
    // other resets: kept end-run results, then the default begin run
    wrc(OFS_COMP_A, 32'h0012_3456);
    wrc(OFS_TRIG, 32'h0000_0000);
    wrc(OFS_CTRL, 32'h0000_00E0);
    idle(4);
    cyc(16'h7000, 2'b10, 1'b0, 1'b0, 8'h00);
    idle(2);
    pulse_sys_reset();
    idle(2);
    rdc(OFS_CTRL, 32'h0000_0080);
    armed(1'b0);
    rdc(OFS_TRIG, 32'h0000_0000);
    rdc(OFS_COMP_A, 32'h0012_3456);
    rdc(OFS_COUNT, 32'h0000_0001);
    wrc(OFS_TRIG, 32'h0000_0040);
    pulse_sys_reset();
    idle(2);
    rdc(OFS_CTRL, 32'h0000_00C0);
    rdc(OFS_TRIG, 32'h0000_0040);
    rdc(OFS_COMP_A, 32'h0000_FFFE);
    // both event-only modes with end storing selected still run as begin runs
    for (int m = 3; m <= 4; m++) begin
      wrc(OFS_CTRL, 32'h0000_0080);
      wrc(OFS_TRIG, 32'(m));
      wrc(OFS_CTRL, 32'h0000_00C0);
      idle(4);
      for (int i = 0; i < 9; i++) begin
        dv = 8'(8'h50 + m * 16 + i);
        cyc(16'hC000, 2'b10, 1'b1, 1'b0, dv);
        if (i < 8) exp_q.push_back({8'h00, dv});
      end
      idle(4);
      rdc(OFS_CTRL, 32'h0000_0080);
      rdc(OFS_COUNT, 32'h0000_0008);
      drain(m == 4);
    end
    // profile sampling through unarmed low byte reads
    wrc(OFS_TRIG, 32'h0000_0040);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      core_in.op_addr <= 16'h9000 + 16'(i) * 16'h0111;
      exp_q.push_back(16'h9000 + 16'(i) * 16'h0111);
      u_host.rd(OFS_FIFO_LO, d, r);
    end
    drain(1'b0);
    wrc(OFS_CTRL, 32'h0000_0000);
    rdc(OFS_FIFO_LO, 32'h0000_0000);
    chk({31'h0, rr_bad}, 32'h0000_0000);
    wrap_up();
  end
endmodule
